// *** pst_pkg.sv ***
package pst_pkg;

  // ---------------------------------------------------------------
  // bus and data widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned NUM_W       = 4;
  localparam int unsigned RAW_W       = 27;
  localparam int unsigned REG_IDX_W   = 8;

  // ---------------------------------------------------------------
  // register byte offsets (telegram bytes 8..19 keep their numbers)
  // ---------------------------------------------------------------
  localparam logic [REG_IDX_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [REG_IDX_W-1:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [REG_IDX_W-1:0] OFF_SCAN_CNT = 8'h08;
  localparam logic [REG_IDX_W-1:0] OFF_FUNC_A   = 8'h0C;
  localparam logic [REG_IDX_W-1:0] OFF_FUNC_B   = 8'h10;
  localparam logic [REG_IDX_W-1:0] OFF_IRQ_EN   = 8'h14;
  localparam logic [REG_IDX_W-1:0] OFF_IRQ_CLR  = 8'h18;

  // ---------------------------------------------------------------
  // control register fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_UPD_EN_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_RST  = 32'h0000_0001;
  localparam logic [DATA_W-1:0] WORD_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CNT_RST   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // interrupt event bits
  // ---------------------------------------------------------------
  localparam int unsigned IRQ_W          = 5;
  localparam int unsigned IRQ_SCAN_BIT   = 0;
  localparam int unsigned IRQ_A_PROT_BIT = 1;
  localparam int unsigned IRQ_B_PROT_BIT = 2;
  localparam int unsigned IRQ_A_RST_BIT  = 3;
  localparam int unsigned IRQ_B_RST_BIT  = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 5'h00;

  // ---------------------------------------------------------------
  // field positions inside one function's status word
  // byte n of the telegram sits in lane (n mod 4)
  // ---------------------------------------------------------------
  localparam int unsigned ST_ACTIVE_BIT  = 7;
  localparam int unsigned ST_WARN_BIT    = 6;
  localparam int unsigned ST_PROT_BIT    = 5;
  localparam int unsigned ST_RESTART_BIT = 4;
  localparam int unsigned ST_SWOUT_BIT   = 3;
  localparam int unsigned SEG_WARN1_BIT  = 7;
  localparam int unsigned SEG_WARN2_BIT  = 6;
  localparam int unsigned SEG_PROT1_BIT  = 5;
  localparam int unsigned SEG_PROT2_BIT  = 4;
  localparam int unsigned SEG_PAIR1_BIT  = 3;
  localparam int unsigned SEG_PAIR2_BIT  = 2;

  // ---------------------------------------------------------------
  // ahb-lite encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage : pst_pkg

// *** pst_func_pack.sv ***
`timescale 1ns/1ns
module pst_func_pack
  import pst_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [pst_pkg::RAW_W-1:0] raw_state,
  input  wire logic                      snap,
  output logic      [pst_pkg::DATA_W-1:0] word_q,
  output logic                           prot_viol_q,
  output logic                           restart_req_q
);

  // ---------------------------------------------------------------
  // two-stage synchroniser per status pin
  // ---------------------------------------------------------------
  logic [RAW_W-1:0] meta_q;
  logic [RAW_W-1:0] sync_q;
  logic             prot_free_dly_q;
  logic             restart_dly_q;

  genvar gi;
  generate
    for (gi = 0; gi < RAW_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_state[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // field unpack, raw layout: status[26:22] numbers[21:6] seg[5:0]
  // ---------------------------------------------------------------
  wire       f_active   = sync_q[26];
  wire       f_warn     = sync_q[25];
  wire       f_prot     = sync_q[24];
  wire       f_restart  = sync_q[23];
  wire       f_swout    = sync_q[22];
  wire [3:0] f_bank     = sync_q[21:18];
  wire [3:0] f_pair1    = sync_q[17:14];
  wire [3:0] f_pair2    = sync_q[13:10];
  wire [3:0] f_pair3    = sync_q[9:6];
  wire [5:0] f_seg      = sync_q[5:0];

  // ---------------------------------------------------------------
  // telegram bytes of one function
  // ---------------------------------------------------------------
  wire [7:0] byte_status;
  wire [7:0] byte_sel1;
  wire [7:0] byte_sel2;
  wire [7:0] byte_seg;

  assign byte_status = {f_active, f_warn, f_prot, f_restart, f_swout, 3'h0};
  assign byte_sel1   = {f_bank, f_pair1};
  assign byte_sel2   = {f_pair2, f_pair3};
  assign byte_seg    = {f_seg, 2'h0};

  // violation means the free flag dropped while the function is active
  wire prot_fall   = prot_free_dly_q & ~f_prot & f_active;
  wire restart_ris = ~restart_dly_q & f_restart;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_q          <= WORD_RST;
      prot_free_dly_q <= 1'b0;
      restart_dly_q   <= 1'b0;
      prot_viol_q     <= 1'b0;
      restart_req_q   <= 1'b0;
    end else begin
      if (snap) begin
        word_q <= {byte_seg, byte_sel2, byte_sel1, byte_status};
      end
      prot_free_dly_q <= f_prot;
      restart_dly_q   <= f_restart;
      prot_viol_q     <= prot_fall;
      restart_req_q   <= restart_ris;
    end
  end

endmodule : pst_func_pack

// *** pst_packer.sv ***
`timescale 1ns/1ns
// What this block does
// - Byte 12 bit 7 shows whether function A is configured and active, zero after reset.
// - Byte 12 bit 6 shows function A's warning field, one when free, zero on violation.
// - Byte 12 bit 5 shows function A's protective field, one when free, zero on violation.
// - Byte 12 bit 4 is one while function A's restart interlock requests a start.
// - Byte 12 bit 3 mirrors function A's internal safety switching output.
// - Byte 13 holds function A's bank in the high nibble and first field pair low.
// - Byte 14 holds function A's second field pair high and third field pair low.
// - Byte 15 bits 7 to 4 hold function A's warning and protective segment flags.
// - Byte 15 bits 3 and 2 flag that defined field pair 1 or 2 of function A is chosen.
// - Byte 16 bit 7 shows whether function B is configured and active.
// - Byte 16 bits 6 and 5 show function B's warning and protective fields, one when free.
// - Byte 16 bit 4 is function B's restart request and bit 3 its switching output.
// - Bytes 17 and 18 hold function B's bank and three field pairs like function A.
// - Byte 19 holds function B's segment and defined-pair flags like byte 15.
// - Bytes 8 to 11 hold a 32-bit scan counter, one more per scan, zero after power-up.
module pst_packer
  import pst_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        hsel,
  input  wire logic [pst_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [pst_pkg::DATA_W-1:0]  hwdata,
  input  wire logic                        hready,
  output logic      [pst_pkg::DATA_W-1:0]  hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        scan_tick,
  input  wire logic                        func_a_active,
  input  wire logic                        func_a_warn_field_free,
  input  wire logic                        func_a_prot_field_free,
  input  wire logic                        func_a_restart_lock,
  input  wire logic                        func_a_safety_switching_output,
  input  wire logic [pst_pkg::NUM_W-1:0]   func_a_bank_num,
  input  wire logic [pst_pkg::NUM_W-1:0]   func_a_pair1_num,
  input  wire logic [pst_pkg::NUM_W-1:0]   func_a_pair2_num,
  input  wire logic [pst_pkg::NUM_W-1:0]   func_a_pair3_num,
  input  wire logic                        func_a_warn_seg1_free,
  input  wire logic                        func_a_warn_seg2_free,
  input  wire logic                        func_a_prot_seg1_free,
  input  wire logic                        func_a_prot_seg2_free,
  input  wire logic                        func_a_defined_pair1_chosen,
  input  wire logic                        func_a_defined_pair2_chosen,
  input  wire logic                        func_b_active,
  input  wire logic                        func_b_warn_field_free,
  input  wire logic                        func_b_prot_field_free,
  input  wire logic                        func_b_restart_lock,
  input  wire logic                        func_b_safety_switching_output,
  input  wire logic [pst_pkg::NUM_W-1:0]   func_b_bank_num,
  input  wire logic [pst_pkg::NUM_W-1:0]   func_b_pair1_num,
  input  wire logic [pst_pkg::NUM_W-1:0]   func_b_pair2_num,
  input  wire logic [pst_pkg::NUM_W-1:0]   func_b_pair3_num,
  input  wire logic                        func_b_warn_seg1_free,
  input  wire logic                        func_b_warn_seg2_free,
  input  wire logic                        func_b_prot_seg1_free,
  input  wire logic                        func_b_prot_seg2_free,
  input  wire logic                        func_b_defined_pair1_chosen,
  input  wire logic                        func_b_defined_pair2_chosen,
  output logic      [pst_pkg::DATA_W-1:0]  scan_count_q,
  output logic      [pst_pkg::DATA_W-1:0]  telegram_a_q,
  output logic      [pst_pkg::DATA_W-1:0]  telegram_b_q,
  output logic                             irq
);

  // ---------------------------------------------------------------
  // internal state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]    ctrl_q;
  logic [IRQ_W-1:0]     irq_stat_q;
  logic [IRQ_W-1:0]     irq_en_q;
  logic                 irq_q;
  logic [DATA_W-1:0]    hrdata_q;
  logic                 hreadyout_q;
  logic                 hresp_q;
  logic                 wr_pend_q;
  logic [REG_IDX_W-1:0] wr_addr_q;
  logic [DATA_W-1:0]    word_a;
  logic [DATA_W-1:0]    word_b;
  logic                 a_prot_viol;
  logic                 b_prot_viol;
  logic                 a_restart_req;
  logic                 b_restart_req;

  // ---------------------------------------------------------------
  // raw status vectors, one per function
  // ---------------------------------------------------------------
  wire [RAW_W-1:0] raw_a;
  wire [RAW_W-1:0] raw_b;

  assign raw_a = {func_a_active, func_a_warn_field_free, func_a_prot_field_free,
                  func_a_restart_lock, func_a_safety_switching_output,
                  func_a_bank_num, func_a_pair1_num, func_a_pair2_num, func_a_pair3_num,
                  func_a_warn_seg1_free, func_a_warn_seg2_free,
                  func_a_prot_seg1_free, func_a_prot_seg2_free,
                  func_a_defined_pair1_chosen, func_a_defined_pair2_chosen};

  assign raw_b = {func_b_active, func_b_warn_field_free, func_b_prot_field_free,
                  func_b_restart_lock, func_b_safety_switching_output,
                  func_b_bank_num, func_b_pair1_num, func_b_pair2_num, func_b_pair3_num,
                  func_b_warn_seg1_free, func_b_warn_seg2_free,
                  func_b_prot_seg1_free, func_b_prot_seg2_free,
                  func_b_defined_pair1_chosen, func_b_defined_pair2_chosen};

  // ---------------------------------------------------------------
  // snapshot control
  // ---------------------------------------------------------------
  // with updates disabled the telegram freezes but the counter still counts,
  // so software can see how many scans went by while it was frozen
  wire upd_en = ctrl_q[CTRL_UPD_EN_BIT];
  wire snap   = scan_tick & upd_en;

  // ---------------------------------------------------------------
  // per-function packers
  // ---------------------------------------------------------------
  pst_func_pack u_pack_a (
    .clk           (clk),
    .rst_n         (rst_n),
    .raw_state     (raw_a),
    .snap          (snap),
    .word_q        (word_a),
    .prot_viol_q   (a_prot_viol),
    .restart_req_q (a_restart_req)
  );

  pst_func_pack u_pack_b (
    .clk           (clk),
    .rst_n         (rst_n),
    .raw_state     (raw_b),
    .snap          (snap),
    .word_q        (word_b),
    .prot_viol_q   (b_prot_viol),
    .restart_req_q (b_restart_req)
  );

  // ---------------------------------------------------------------
  // scan counter
  // ---------------------------------------------------------------
  // wraps silently after 2^32 scans; only reset brings it back to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_count_q <= CNT_RST;
    end else if (scan_tick) begin
      scan_count_q <= scan_count_q + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite decode
  // ---------------------------------------------------------------
  wire                 addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire                 rd_req     = addr_phase & ~hwrite;
  wire                 wr_req     = addr_phase & hwrite;
  wire [REG_IDX_W-1:0] a_idx      = haddr[REG_IDX_W-1:0];
  wire                 wr_ctrl    = wr_pend_q & (wr_addr_q == OFF_CTRL);
  wire                 wr_en      = wr_pend_q & (wr_addr_q == OFF_IRQ_EN);
  wire                 wr_clr     = wr_pend_q & (wr_addr_q == OFF_IRQ_CLR);

  // read mux; the clear register is write-only and reads zero
  wire [DATA_W-1:0] rd_val =
    (a_idx == OFF_CTRL)     ? ctrl_q :
    (a_idx == OFF_IRQ_STAT) ? {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q} :
    (a_idx == OFF_SCAN_CNT) ? scan_count_q :
    (a_idx == OFF_FUNC_A)   ? word_a :
    (a_idx == OFF_FUNC_B)   ? word_b :
    (a_idx == OFF_IRQ_EN)   ? {{(DATA_W-IRQ_W){1'b0}}, irq_en_q} :
                              WORD_RST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= OFF_CTRL;
      hrdata_q    <= WORD_RST;
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
    end else begin
      wr_pend_q   <= wr_req;
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
      if (wr_req) begin
        wr_addr_q <= a_idx;
      end
      if (rd_req) begin
        hrdata_q <= rd_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {{(DATA_W-1){1'b0}}, hwdata[CTRL_UPD_EN_BIT]};
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  wire [IRQ_W-1:0] irq_evt;
  wire [IRQ_W-1:0] irq_clr;

  assign irq_evt[IRQ_SCAN_BIT]   = scan_tick;
  assign irq_evt[IRQ_A_PROT_BIT] = a_prot_viol;
  assign irq_evt[IRQ_B_PROT_BIT] = b_prot_viol;
  assign irq_evt[IRQ_A_RST_BIT]  = a_restart_req;
  assign irq_evt[IRQ_B_RST_BIT]  = b_restart_req;
  assign irq_clr = wr_clr ? hwdata[IRQ_W-1:0] : IRQ_RST;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= IRQ_RST;
      irq_en_q   <= IRQ_RST;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      if (wr_en) begin
        irq_en_q <= hwdata[IRQ_W-1:0];
      end
      irq_q <= |(((irq_stat_q & ~irq_clr) | irq_evt) & (wr_en ? hwdata[IRQ_W-1:0] : irq_en_q));
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = hresp_q;
  assign telegram_a_q = word_a;
  assign telegram_b_q = word_b;
  assign irq          = irq_q;

endmodule : pst_packer

// *** pst_checker.sv ***
`timescale 1ns/1ns
module pst_checker
  import pst_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        hsel,
  input wire logic [pst_pkg::ADDR_W-1:0]  haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic                        hready,
  input wire logic [pst_pkg::DATA_W-1:0]  hrdata,
  input wire logic                        scan_tick,
  input wire logic                        func_a_active,
  input wire logic                        func_a_prot_seg1_free,
  input wire logic [pst_pkg::NUM_W-1:0]   func_b_bank_num,
  input wire logic [pst_pkg::DATA_W-1:0]  scan_count_q,
  input wire logic [pst_pkg::DATA_W-1:0]  telegram_a_q,
  input wire logic [pst_pkg::DATA_W-1:0]  telegram_b_q
);
  import pst_pkg::*;
  // ---------------------------------------------------------------
  // telegram and bus relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // pins pass two synchroniser stages, so a snapshot shows the pin three samples back
  sequence rd_at(logic [7:0] off);
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr[7:0] == off;
  endsequence
  resv_zero_a: assert property (
    telegram_a_q[2:0] == 3'h0 && telegram_a_q[25:24] == 2'h0 &&
    telegram_b_q[2:0] == 3'h0 && telegram_b_q[25:24] == 2'h0)
    else $error("reserved telegram bits set");
  cnt_step_a: assert property (
    scan_tick |=> scan_count_q == $past(scan_count_q) + 32'h1)
    else $error("scan counter did not step");
  cnt_hold_a: assert property (
    !scan_tick |=> $stable(scan_count_q)) else $error("scan counter moved without scan");
  tel_hold_a: assert property (
    !scan_tick |=> $stable(telegram_a_q) && $stable(telegram_b_q))
    else $error("telegram moved without scan");
  act_follow_a: assert property (
    $changed(telegram_a_q[7]) |-> telegram_a_q[7] == $past(func_a_active, 3))
    else $error("active flag a not from pin");
  seg_follow_a: assert property (
    $changed(telegram_a_q[29]) |-> telegram_a_q[29] == $past(func_a_prot_seg1_free, 3))
    else $error("segment flag a not from pin");
  bank_follow_a: assert property (
    $changed(telegram_b_q[15:12]) |-> telegram_b_q[15:12] == $past(func_b_bank_num, 3))
    else $error("bank b not from pins");
  rd_cnt_a: assert property (
    rd_at(OFF_SCAN_CNT) |=> hrdata == $past(scan_count_q)) else $error("count read wrong");
  rd_tela_a: assert property (
    rd_at(OFF_FUNC_A) |=> hrdata == $past(telegram_a_q)) else $error("word a read wrong");
  rd_telb_a: assert property (
    rd_at(OFF_FUNC_B) |=> hrdata == $past(telegram_b_q)) else $error("word b read wrong");
endmodule : pst_checker

bind pst_packer pst_checker u_chk (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .scan_tick, .func_a_active, .func_a_prot_seg1_free, .func_b_bank_num,
  .scan_count_q, .telegram_a_q, .telegram_b_q);

// *** pst_host.sv ***
`timescale 1ns/1ns
module pst_host
  import pst_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        hready,
  input  wire logic [pst_pkg::DATA_W-1:0]  hrdata,
  output logic                             hsel,
  output logic      [pst_pkg::ADDR_W-1:0]  haddr,
  output logic      [1:0]                  htrans,
  output logic                             hwrite,
  output logic      [2:0]                  hsize,
  output logic      [pst_pkg::DATA_W-1:0]  hwdata
);
  import pst_pkg::*;
  // ---------------------------------------------------------------
  // single word transfers, waiting on hready at every phase
  // ---------------------------------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    // idle write data is inverted so a stale value cannot pass as a fresh one
    hwdata <= ~d;
  endtask : xfer
endmodule : pst_host

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import pst_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic        clk, rst_n, scan_tick;
  logic [26:0] a_v, b_v, exp_a;
  logic [31:0] rd;
  int          n_errors, tests_run, nt;
  wire logic        hsel, hwrite, hready, hresp, irq;
  wire logic [31:0] haddr, hwdata, hrdata, cnt_q, tel_a, tel_b;
  wire logic [1:0]  htrans;
  wire logic [2:0]  hsize;
  pst_host u_host (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  pst_packer u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .scan_tick(scan_tick),
    .func_a_active(a_v[26]), .func_a_warn_field_free(a_v[25]), .func_a_prot_field_free(a_v[24]),
    .func_a_restart_lock(a_v[23]), .func_a_safety_switching_output(a_v[22]),
    .func_a_bank_num(a_v[21:18]), .func_a_pair1_num(a_v[17:14]), .func_a_pair2_num(a_v[13:10]),
    .func_a_pair3_num(a_v[9:6]), .func_a_warn_seg1_free(a_v[5]), .func_a_warn_seg2_free(a_v[4]),
    .func_a_prot_seg1_free(a_v[3]), .func_a_prot_seg2_free(a_v[2]),
    .func_a_defined_pair1_chosen(a_v[1]), .func_a_defined_pair2_chosen(a_v[0]),
    .func_b_active(b_v[26]), .func_b_warn_field_free(b_v[25]), .func_b_prot_field_free(b_v[24]),
    .func_b_restart_lock(b_v[23]), .func_b_safety_switching_output(b_v[22]),
    .func_b_bank_num(b_v[21:18]), .func_b_pair1_num(b_v[17:14]), .func_b_pair2_num(b_v[13:10]),
    .func_b_pair3_num(b_v[9:6]), .func_b_warn_seg1_free(b_v[5]), .func_b_warn_seg2_free(b_v[4]),
    .func_b_prot_seg1_free(b_v[3]), .func_b_prot_seg2_free(b_v[2]),
    .func_b_defined_pair1_chosen(b_v[1]), .func_b_defined_pair2_chosen(b_v[0]),
    .scan_count_q(cnt_q), .telegram_a_q(tel_a), .telegram_b_q(tel_b), .irq(irq));
  always #25 clk = ~clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] ex(input logic [26:0] v);
    return {v[5:0], 2'h0, v[13:6], v[21:14], v[26:22], 3'h0};
  endfunction : ex
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdw(input logic [31:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, rd);
  endtask : rdw
  task automatic wrw(input logic [31:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd);
  endtask : wrw
  task automatic tick_n(input int n);
    repeat (n) begin
      @(posedge clk);
      scan_tick <= 1'b1;
      nt++;
    end
    @(posedge clk);
    scan_tick <= 1'b0;
    @(negedge clk);
  endtask : tick_n
  task automatic set_pins(input logic [26:0] a, input logic [26:0] b);
    @(posedge clk);
    a_v <= a;
    b_v <= b;
    // room for the two synchroniser stages before the next snapshot
    repeat (3) @(posedge clk);
  endtask : set_pins
  task automatic wait_irq(input logic e);
    for (int k = 0; k < 10 && irq !== e; k++) @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : wait_irq
  task automatic finish_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk(tel_a, 32'h0000_0000);
    chk(tel_b, 32'h0000_0000);
    chk(cnt_q, 32'h0000_0000);
    rdw(OFF_CTRL);
    chk(rd, CTRL_RST);
    rdw(OFF_IRQ_EN);
    chk(rd, 32'h0000_0000);
    rdw(32'h0000_0040);
    chk(rd, 32'h0000_0000);
  endtask : t_reset
  task automatic t_pack;
    logic [26:0] pat [4] = '{{5'h1F, 16'hAAAA, 6'h3F}, {5'h15, 16'h1234, 6'h2A},
                             {5'h0A, 16'h5678, 6'h15}, {5'h00, 16'h91A2, 6'h00}};
    for (int i = 0; i < 4; i++) begin
      set_pins(pat[i], pat[3-i]);
      tick_n(1);
      chk(tel_a, ex(pat[i]));
      chk(tel_b, ex(pat[3-i]));
      rdw(OFF_FUNC_A);
      chk(rd, ex(pat[i]));
      rdw(OFF_FUNC_B);
      chk(rd, ex(pat[3-i]));
      exp_a = pat[i];
    end
  endtask : t_pack
  task automatic t_freeze;
    wrw(OFF_CTRL, 32'h0000_0000);
    set_pins(27'h400_0000, 27'h400_0000);
    tick_n(3);
    chk(tel_a, ex(exp_a));
    chk(cnt_q, nt);
    wrw(OFF_CTRL, 32'h0000_0001);
    tick_n(1);
    chk(tel_a, ex(27'h400_0000));
    chk(tel_b, ex(27'h400_0000));
    wrw(OFF_FUNC_A, 32'hFFFF_FFFF);
    chk({31'h0, hresp}, 32'h0000_0000);
    rdw(OFF_FUNC_A);
    chk(rd, ex(27'h400_0000));
    rdw(OFF_SCAN_CNT);
    chk(rd, nt);
  endtask : t_freeze
  task automatic t_irq;
    wrw(OFF_IRQ_CLR, 32'h0000_001F);
    rdw(OFF_IRQ_STAT);
    chk(rd, 32'h0000_0000);
    wrw(OFF_IRQ_EN, 32'h0000_0001);
    tick_n(1);
    wait_irq(1'b1);
    wrw(OFF_IRQ_CLR, 32'h0000_0001);
    wait_irq(1'b0);
    // restart rise and prot free are masked, so irq must stay low
    set_pins(27'h580_0000, 27'h000_0000);
    repeat (5) @(posedge clk);
    wait_irq(1'b0);
    rdw(OFF_IRQ_STAT);
    chk(rd, 32'h0000_0008);
    wrw(OFF_IRQ_EN, 32'h0000_0002);
    set_pins(27'h480_0000, 27'h000_0000);
    wait_irq(1'b1);
    rdw(OFF_IRQ_STAT);
    chk(rd, 32'h0000_000A);
    wrw(OFF_IRQ_CLR, 32'h0000_001F);
    wait_irq(1'b0);
    // function b events: restart rise, then protective field loss while active
    wrw(OFF_IRQ_EN, 32'h0000_0014);
    set_pins(27'h000_0000, 27'h580_0000);
    wait_irq(1'b1);
    set_pins(27'h000_0000, 27'h480_0000);
    rdw(OFF_IRQ_STAT);
    chk(rd, 32'h0000_0014);
    wrw(OFF_IRQ_CLR, 32'h0000_001F);
    wait_irq(1'b0);
  endtask : t_irq
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    scan_tick = 1'b0;
    a_v = 27'h0;
    b_v = 27'h0;
    exp_a = 27'h0;
    n_errors = 0;
    tests_run = 0;
    nt = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset;
    t_pack;
    t_freeze;
    t_irq;
    finish_test;
  end
  initial begin
    #2000000;
    n_errors++;
    finish_test;
  end
endmodule : testbench
